// >>> hdl/brs_cmd.sv
// Serial-bus slave command interpreter for line read-byte and search triplet
//
// Function
// RQ1: Without polling, host waits long enough for read-byte to finish before reading.
// RQ2: Set-read-pointer with code E1h makes next read return received byte.
// RQ3: Pointer to read data is accepted while a read-byte is running.
// RQ4: Polling reads keep returning live status until busy clears.
// RQ5: Line commands are not acknowledged while busy; host stops and retries.
// RQ6: When busy falls after a triplet, status holds the triplet result.
// RQ7: After a triplet, a plain read returns the status with the result.
// RQ8: Serial clock is input only; the device never stretches it.
// RQ9: Serial data is driven low only; high comes from the pull-up.
// RQ10: Busy flag is one while a line operation runs, zero after.
// RQ11: Read data stays stable until the next read-byte completes.
`timescale 1ns/1ps
module brs_cmd #(
  parameter logic [6:0] DEV_ADDR = brs_pkg::DEV_ADDR_DFLT
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_out,
  output logic            o_sda_oe,
  output logic            o_line_read_start,
  output logic            o_triplet_start,
  output logic            o_triplet_dir,
  output logic            o_line_busy_flag,
  input  wire logic       i_line_done,
  input  wire logic [7:0] i_line_byte,
  input  wire logic [2:0] i_triplet_bits
);
  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_ADDR = 9'h002,
    S_AACK = 9'h004,
    S_CMD  = 9'h008,
    S_CACK = 9'h010,
    S_ARG  = 9'h020,
    S_GACK = 9'h040,
    S_TX   = 9'h080,
    S_MACK = 9'h100
  } brs_state_t;

  typedef struct packed {
    brs_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic [7:0] cmd;
    logic       rw;
    logic       nack;
    logic       busy;
    logic       trip_op;
    logic [7:0] rdata;
    logic [2:0] trip;
    logic       sda_oe;
    logic       sda_out;
    logic       rd_start;
    logic       tr_start;
    logic       tr_dir;
    logic       scl_q;
    logic       sda_q;
  } brs_regs_t;

  brs_regs_t  s_reg;
  brs_regs_t  s_next;
  logic [1:0] pins_sync;
  logic       scl_s;
  logic       sda_s;
  // RQ8 RQ9: no clock output exists; data pin is only ever pulled low
  brs_sync #(.WIDTH (2)) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_async   ({i_scl, i_sda}),
    .o_sync    (pins_sync)
  );
  assign scl_s = pins_sync[1];
  assign sda_s = pins_sync[0];

  // ------------------------------------------------------------------
  // Decoding helpers
  // ------------------------------------------------------------------
  function automatic logic [7:0] read_mux(input brs_regs_t r);
    logic [7:0] stat;
    stat = 8'h00;
    stat[brs_pkg::STAT_BUSY_BIT] = r.busy;
    stat[brs_pkg::STAT_TRIP_LSB +: brs_pkg::TRIP_W] = r.trip;
    if (r.ptr == brs_pkg::PTR_RDATA)
      read_mux = r.rdata;                                        // RQ2
    else
      read_mux = stat;                                           // RQ4
  endfunction : read_mux
  function automatic logic ptr_valid(input logic [7:0] p);
    ptr_valid = (p == brs_pkg::PTR_RDATA) || (p == brs_pkg::PTR_STATUS);
  endfunction : ptr_valid

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb
  begin
    logic scl_rise, scl_fall, start_c, stop_c;
    logic [7:0] tx;
    scl_rise = scl_s && !s_reg.scl_q;
    scl_fall = !scl_s && s_reg.scl_q;
    start_c  = scl_s && s_reg.scl_q && s_reg.sda_q && !sda_s;
    stop_c   = scl_s && s_reg.scl_q && !s_reg.sda_q && sda_s;
    tx       = read_mux(s_reg);
    s_next          = s_reg;
    s_next.scl_q    = scl_s;
    s_next.sda_q    = sda_s;
    s_next.rd_start = 1'b0;
    s_next.tr_start = 1'b0;
    s_next.sda_out  = 1'b0;                                      // RQ9
    // Completion from the line engine
    if (i_line_done)
    begin
      s_next.busy = 1'b0;                                        // RQ10
      if (s_reg.trip_op)
        s_next.trip = i_triplet_bits;                            // RQ6
      else
        s_next.rdata = i_line_byte;                              // RQ11
    end
    if (start_c)
    begin
      s_next.st     = S_ADDR;
      s_next.cnt    = 4'h0;
      s_next.sda_oe = 1'b0;
    end
    else if (stop_c)
    begin
      s_next.st     = S_IDLE;
      s_next.sda_oe = 1'b0;
    end
    else if (scl_rise)
    begin
      case (s_next.st)
        S_ADDR, S_CMD, S_ARG:
        begin
          s_next.sh  = {s_reg.sh[6:0], sda_s};
          s_next.cnt = s_reg.cnt + 4'h1;
        end
        // A not-acknowledge from the master ends the read burst
        S_MACK:
          if (sda_s)
            s_next.st = S_IDLE;
        default: s_next.st = s_reg.st;
      endcase
    end
    else if (scl_fall)
    begin
      case (s_reg.st)
        S_ADDR:
          if (s_reg.cnt == brs_pkg::BITS_PER_BYTE)
          begin
            if (s_reg.sh[7:1] == DEV_ADDR)
            begin
              s_next.rw     = s_reg.sh[0];
              s_next.sda_oe = 1'b1;
              s_next.st     = S_AACK;
            end
            else
              s_next.st = S_IDLE;
          end
        S_AACK:
          if (s_reg.rw)
          begin
            s_next.sh     = tx;
            s_next.sda_oe = !tx[7];
            s_next.cnt    = 4'h1;
            s_next.st     = S_TX;
          end
          else
          begin
            s_next.sda_oe = 1'b0;
            s_next.cnt    = 4'h0;
            s_next.st     = S_CMD;
          end
        S_CMD:
        begin
          if (s_reg.cnt == brs_pkg::BITS_PER_BYTE)
          begin
            s_next.cmd  = s_reg.sh;
            s_next.nack = 1'b0;
            s_next.st   = S_CACK;
            case (s_reg.sh)
              brs_pkg::CMD_SET_READ_PTR: s_next.nack = 1'b0;     // RQ3
              brs_pkg::CMD_LINE_READ:
              begin
                if (s_reg.busy)
                  s_next.nack = 1'b1;                            // RQ5
                else
                begin
                  s_next.rd_start = 1'b1;
                  s_next.busy     = 1'b1;                        // RQ10
                  s_next.trip_op  = 1'b0;
                  s_next.ptr      = brs_pkg::PTR_STATUS;         // RQ1
                end
              end
              brs_pkg::CMD_SEARCH_TRIP: s_next.nack = s_reg.busy; // RQ5
              default: s_next.nack = 1'b1;
            endcase
            s_next.sda_oe = !s_next.nack;
          end
        end
        S_CACK:
        begin
          s_next.sda_oe = 1'b0;
          s_next.cnt    = 4'h0;
          s_next.st = (s_reg.nack || s_reg.cmd == brs_pkg::CMD_LINE_READ) ? S_IDLE : S_ARG;
        end
        S_ARG:
        begin
          if (s_reg.cnt == brs_pkg::BITS_PER_BYTE)
          begin
            s_next.st   = S_GACK;
            s_next.nack = 1'b0;
            if (s_reg.cmd == brs_pkg::CMD_SET_READ_PTR)
            begin
              if (ptr_valid(s_reg.sh))
                s_next.ptr = s_reg.sh;                           // RQ2
              else
                s_next.nack = 1'b1;
            end
            else
            begin
              s_next.tr_start = 1'b1;
              s_next.tr_dir   = s_reg.sh[7];
              s_next.busy     = 1'b1;                            // RQ10
              s_next.trip_op  = 1'b1;
              s_next.ptr      = brs_pkg::PTR_STATUS;             // RQ7
            end
            s_next.sda_oe = !s_next.nack;
          end
        end
        S_GACK:
        begin
          // Further bytes wait for a repeated start or a stop
          s_next.sda_oe = 1'b0;
          s_next.st     = S_IDLE;
        end
        S_TX:
          if (s_reg.cnt == brs_pkg::BITS_PER_BYTE)
          begin
            s_next.sda_oe = 1'b0;
            s_next.st     = S_MACK;
          end
          else
          begin
            s_next.sda_oe = !s_reg.sh[6];
            s_next.sh     = {s_reg.sh[6:0], 1'b0};
            s_next.cnt    = s_reg.cnt + 4'h1;
          end
        S_MACK:
        begin
          // Fresh sample each byte so polling sees busy fall
          s_next.sh     = tx;                                    // RQ4
          s_next.sda_oe = !tx[7];
          s_next.cnt    = 4'h1;
          s_next.st     = S_TX;
        end
        default: s_next.st = S_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      s_reg       <= '0;
      s_reg.st    <= S_IDLE;
      s_reg.ptr   <= brs_pkg::PTR_STATUS;
      s_reg.rdata <= brs_pkg::RDATA_RST;
      s_reg.trip  <= brs_pkg::TRIP_RST;
      s_reg.scl_q <= 1'b1;
      s_reg.sda_q <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  assign o_sda_out         = s_reg.sda_out;
  assign o_sda_oe          = s_reg.sda_oe;
  assign o_line_read_start = s_reg.rd_start;
  assign o_triplet_start   = s_reg.tr_start;
  assign o_triplet_dir     = s_reg.tr_dir;
  assign o_line_busy_flag  = s_reg.busy;
endmodule : brs_cmd

// >>> hdl/brs_pkg.sv
// Shared constants of the read-byte / triplet command interpreter
package brs_pkg;
  // ------------------------------------------------------------------
  // Pointer codes
  // ------------------------------------------------------------------
  localparam logic [7:0] PTR_RDATA  = 8'hE1;
  localparam logic [7:0] PTR_STATUS = 8'hF0;
  // ------------------------------------------------------------------
  // Command codes
  // ------------------------------------------------------------------
  localparam logic [7:0] CMD_SET_READ_PTR  = 8'hD2;
  localparam logic [7:0] CMD_LINE_READ     = 8'h96;
  localparam logic [7:0] CMD_SEARCH_TRIP   = 8'h78;
  // ------------------------------------------------------------------
  // Status register fields, reset values and other shared constants
  // ------------------------------------------------------------------
  localparam int         STAT_BUSY_BIT  = 0;
  localparam int         STAT_TRIP_LSB  = 5;
  localparam int         TRIP_W         = 3;
  localparam logic [7:0] RDATA_RST      = 8'h00;
  localparam logic [2:0] TRIP_RST       = 3'h0;
  localparam logic [6:0] DEV_ADDR_DFLT  = 7'h18;
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
  localparam int         SYNC_STAGES    = 2;
endpackage : brs_pkg

// >>> hdl/brs_sync.sv
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module brs_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rstn,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_reg;

  initial
  begin
    if (WIDTH < 1) $error("brs_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      meta_reg <= '1;
      o_sync   <= '1;
    end
    else
    begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end
endmodule : brs_sync

// >>> test/brs_cmd_checker.sv
// Port-level assertions for the command interpreter
`timescale 1ns/1ps
module brs_cmd_checker (
  input wire logic       i_sys_clk,
  input wire logic       i_rstn,
  input wire logic       i_scl,
  input wire logic       o_sda_out,
  input wire logic       o_sda_oe,
  input wire logic       o_line_read_start,
  input wire logic       o_triplet_start,
  input wire logic       o_line_busy_flag,
  input wire logic       i_line_done
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  property p_rd; o_line_read_start |-> o_line_busy_flag && !$past(o_line_busy_flag); endproperty
  property p_tr; o_triplet_start |-> o_line_busy_flag && !$past(o_line_busy_flag); endproperty
  property p_clr; o_line_busy_flag && i_line_done |=> !o_line_busy_flag; endproperty
  property p_hold; o_line_busy_flag && !i_line_done |=> o_line_busy_flag; endproperty
  property p_rise; $rose(o_line_busy_flag) |-> o_line_read_start || o_triplet_start; endproperty
  property p_pulse; o_line_read_start || o_triplet_start |=> !(o_line_read_start || o_triplet_start);
  endproperty
  property p_low; o_sda_oe |-> o_sda_out == 1'b0; endproperty
  property p_edge; $changed(o_sda_oe) |-> !i_scl; endproperty
  a_rd: assert property (p_rd) else $error("read start while busy");
  a_tr: assert property (p_tr) else $error("triplet start while busy");
  a_clr: assert property (p_clr) else $error("busy not cleared");
  a_hold: assert property (p_hold) else $error("busy dropped early");
  a_rise: assert property (p_rise) else $error("busy without start");
  a_pulse: assert property (p_pulse) else $error("start too long");
  a_low: assert property (p_low) else $error("data driven high");
  a_edge: assert property (p_edge) else $error("data moved with clock high");
  c_rd: cover property (o_line_read_start);
  c_tr: cover property (o_triplet_start);
  c_done: cover property (o_line_busy_flag && i_line_done);
endmodule : brs_cmd_checker
bind brs_cmd brs_cmd_checker u_chk (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_scl(i_scl),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_line_read_start(o_line_read_start),
  .o_triplet_start(o_triplet_start), .o_line_busy_flag(o_line_busy_flag),
  .i_line_done(i_line_done));

// >>> test/brs_host.sv
// Serial-bus host model driving the bridge pins
`timescale 1ns/1ps
module brs_host (
  input  wire logic i_sys_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_rel
);
  initial
  begin
    o_scl     = 1'b1;
    o_sda_rel = 1'b1;
  end
  // Six clocks per phase stays clear of the slave's 3-clock answer
  task automatic hp();
    repeat (6) @(posedge i_sys_clk);
    #1;
  endtask : hp
  task automatic start();
    o_sda_rel = 1'b1;
    hp();
    o_scl = 1'b1;
    hp();
    o_sda_rel = 1'b0;
    hp();
    o_scl = 1'b0;
  endtask : start
  task automatic stop();
    hp();
    o_sda_rel = 1'b0;
    hp();
    o_scl = 1'b1;
    hp();
    o_sda_rel = 1'b1;
    hp();
  endtask : stop
  task automatic xbit(input logic b, output logic r);
    @(posedge i_sys_clk);
    #1 o_sda_rel = b;
    hp();
    o_scl = 1'b1;
    hp();
    r = i_sda;
    o_scl = 1'b0;
  endtask : xbit
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(d[i], r);
    xbit(1'b1, r);
    ack = ~r;
  endtask : wbyte
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(1'b1, d[i]);
    xbit(last, r);
  endtask : rbyte
endmodule : brs_host

// >>> test/testbench.sv
// Self-checking bench for the read-byte / triplet command interpreter
`timescale 1ns/1ps
module testbench;
  logic       clk, rstn, scl, rel, sda, oe, so, rs, ts, dir, busy, done, ack, op;
  logic [7:0] lb, d, a;
  logic [2:0] tb;
  int         num_errors, checks_done, seed, cyc, m_rd, m_tr, cnt;
  assign sda = rel & ~(oe & ~so);
  brs_cmd u_brs_cmd (.i_sys_clk(clk), .i_rstn(rstn), .i_scl(scl), .i_sda(sda),
    .o_sda_out(so), .o_sda_oe(oe), .o_line_read_start(rs), .o_triplet_start(ts),
    .o_triplet_dir(dir), .o_line_busy_flag(busy), .i_line_done(done), .i_line_byte(lb),
    .i_triplet_bits(tb));
  brs_host u_brs_host (.i_sys_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_rel(rel));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Line engine: long enough that a pointer write fits inside an operation
  always @(posedge clk)
  begin
    done <= #1 (cnt == 1);
    if (cnt > 0) cnt <= cnt - 1;
    if (rs | ts)
    begin
      cnt <= 1000;
      op  <= rs;
      lb  <= #1 8'($random(seed));
      tb  <= #1 3'($random(seed));
    end
    if (done && op) m_rd = lb;
    if (done && !op) m_tr = tb;
    cyc++;
    if (cyc > 80000)
    begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cmd(input logic [7:0] c);
    u_brs_host.start();
    u_brs_host.wbyte({brs_pkg::DEV_ADDR_DFLT, 1'b0}, ack);
    u_brs_host.wbyte(c, ack);
  endtask : cmd
  task automatic rd_start();
    u_brs_host.start();
    u_brs_host.wbyte({brs_pkg::DEV_ADDR_DFLT, 1'b1}, ack);
  endtask : rd_start
  task automatic rd_data();
    cmd(brs_pkg::CMD_SET_READ_PTR);
    u_brs_host.wbyte(brs_pkg::PTR_RDATA, ack);
    rd_start();
    u_brs_host.rbyte(1'b1, d);
    u_brs_host.stop();
  endtask : rd_data
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test
  initial
  begin
    seed = 52;
    rstn = 1'b0;
    done = 1'b0;
    lb   = 8'h00;
    tb   = 3'h0;
    repeat (3) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (4) @(posedge clk);
    rd_start();
    u_brs_host.rbyte(1'b1, d);
    u_brs_host.stop();
    chk(d, {brs_pkg::TRIP_RST, 5'h00});
    rd_data();
    chk(d, brs_pkg::RDATA_RST);
    for (int k = 0; k < 3; k++)
    begin
      cmd(brs_pkg::CMD_LINE_READ);
      chk({7'h00, ack}, 8'h01);
      u_brs_host.stop();
      cmd(k[0] ? brs_pkg::CMD_SEARCH_TRIP : brs_pkg::CMD_LINE_READ);
      chk({7'h00, ack}, 8'h00);
      u_brs_host.stop();
      cmd(brs_pkg::CMD_SET_READ_PTR);
      u_brs_host.wbyte(brs_pkg::PTR_RDATA, ack);
      chk({7'h00, ack}, 8'h01);
      u_brs_host.stop();
      repeat (1200) @(posedge clk);
      rd_start();
      u_brs_host.rbyte(1'b1, d);
      u_brs_host.stop();
      chk(d, m_rd[7:0]);
      cmd(brs_pkg::CMD_LINE_READ);
      rd_start();
      u_brs_host.rbyte(1'b0, d);
      chk(d, {m_tr[2:0], 5'h01});
      for (int p = 0; p < 40 && d[0] !== 1'b0; p++) u_brs_host.rbyte(1'b0, d);
      chk(d, {m_tr[2:0], 5'h00});
      u_brs_host.rbyte(1'b1, d);
      rd_data();
      chk(d, m_rd[7:0]);
      a = 8'($random(seed));
      cmd(brs_pkg::CMD_SEARCH_TRIP);
      u_brs_host.wbyte(a, ack);
      u_brs_host.stop();
      chk({7'h00, dir}, {7'h00, a[7]});
      repeat (1200) @(posedge clk);
      rd_start();
      u_brs_host.rbyte(1'b1, d);
      u_brs_host.stop();
      chk(d, {m_tr[2:0], 5'h00});
      cmd(brs_pkg::CMD_SEARCH_TRIP);
      u_brs_host.wbyte(~a, ack);
      chk({7'h00, ack}, 8'h01);
      rd_start();
      u_brs_host.rbyte(1'b0, d);
      chk({7'h00, d[0]}, 8'h01);
      for (int p = 0; p < 40 && d[0] !== 1'b0; p++) u_brs_host.rbyte(1'b0, d);
      chk(d, {m_tr[2:0], 5'h00});
      u_brs_host.rbyte(1'b1, d);
      u_brs_host.stop();
      rd_data();
      chk(d, m_rd[7:0]);
    end
    end_of_test();
  end
endmodule : testbench
